/* rtl/gtm_regs.svh */
/*
  Register offsets, field positions, reset values and counts for the
  general timer module. Assumes a byte-addressed 32-bit register port.
*/
`ifndef GTM_REGS_SVH
`define GTM_REGS_SVH

`define GTM_OFS_CFG    12'h000
`define GTM_OFS_MODE   12'h004
`define GTM_OFS_CTL    12'h00C
`define GTM_OFS_IMR    12'h018
`define GTM_OFS_RIS    12'h01C
`define GTM_OFS_MIS    12'h020
`define GTM_OFS_ICR    12'h024
`define GTM_OFS_ILR    12'h028
`define GTM_OFS_MATCH  12'h030
`define GTM_OFS_PR     12'h038
`define GTM_OFS_VAL    12'h048

`define GTM_CTL_EN     0
`define GTM_CTL_EVT    2
`define GTM_CTL_RTC_DEBUG_STALL_OVERRIDE  4
`define GTM_CTL_PWML   6

`define GTM_FLAG_TO    0
`define GTM_FLAG_CM    1
`define GTM_FLAG_CE    2
`define GTM_FLAG_RTC   3

`define GTM_ILR_RST    32'hFFFF_FFFF
`define GTM_MATCH_RST  32'hFFFF_FFFF
`define GTM_CNT_RST    32'hFFFF_FFFF
`define GTM_RTC_START  32'h0000_0001
`define GTM_RTC_DIV_LAST 15'h7FFF

`endif

/* rtl/gtm_pkg.sv */
/*
  Types and encodings of the general timer module.
  Assumes gtm_regs.svh supplies offsets and reset values.
*/
package gtm_pkg;

  localparam logic [2:0] GTM_CFG_32  = 3'h0;
  localparam logic [2:0] GTM_CFG_RTC = 3'h1;
  localparam logic [2:0] GTM_CFG_16  = 3'h4;
  localparam logic [1:0] GTM_MR_OS   = 2'h1;
  localparam logic [1:0] GTM_MR_PER  = 2'h2;
  localparam logic [1:0] GTM_MR_CAP  = 2'h3;

  typedef enum logic [3:0] {
    OP_OFF   = 4'b0000,
    OP_OS32  = 4'b0001,
    OP_PER32 = 4'b0010,
    OP_RTC   = 4'b0011,
    OP_OS16  = 4'b0100,
    OP_PER16 = 4'b0101,
    OP_ECNT  = 4'b0110,
    OP_ETIME = 4'b0111,
    OP_PWM   = 4'b1000
  } gtm_op_t;

  typedef struct packed {
    logic       alternate_mode_select;
    logic       capture_mode_select;
    logic [1:0] half_timer_mode_field;
  } gtm_mode_t;

  typedef struct packed {
    logic       half_timer_enable;
    logic [1:0] edge_event_type;
    logic       rtc_debug_stall_override;
    logic       pwm_output_level;
  } gtm_ctl_t;

  typedef struct packed {
    logic [2:0]  cfg;
    gtm_mode_t   mode;
    gtm_ctl_t    ctl;
    logic [3:0]  imr;
    logic [3:0]  ris;
    logic [31:0] ilr;
    logic [31:0] match;
    logic [7:0]  pr;
    logic [7:0]  pre;
    logic [31:0] cnt;
    logic [15:0] cap;
    logic [14:0] rdiv;
    logic        pwm_lvl;
  } gtm_st_t;

endpackage : gtm_pkg

/* rtl/gtm_timer.sv */
/*
  General timer module: one timer unit with 32-bit one-shot/periodic,
  RTC, 16-bit one-shot/periodic, edge count, edge time and PWM modes.
  Assumes a synchronous register port and an asynchronous pin.
*/
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "gtm_regs.svh"
module gtm_timer
  import gtm_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // Capture compare pin
  input  wire logic        ccp_in,
  output logic             ccp_out,
  output logic             ccp_oe
);

  gtm_st_t     st;
  gtm_st_t     next_st;
  logic [2:0]  sync;
  logic [2:0]  next_sync;
  logic        lvl;
  logic        next_lvl;
  logic [31:0] next_rd_data;
  logic        next_ccp_out;
  logic        next_ccp_oe;
  logic        rise;
  logic        fall;
  logic        hit;
  logic        tick;
  logic        wide;
  logic        one_shot;
  gtm_op_t     op;
  logic [31:0] lv;
  logic [3:0]  set;
  logic [3:0]  clr;

  function automatic gtm_op_t op_decode(input logic [2:0] cfg,
                                        input gtm_mode_t m);
    gtm_op_t r;
    r = OP_OFF;
    if (cfg == GTM_CFG_32)
    begin
      if (m.half_timer_mode_field == GTM_MR_OS)
        r = OP_OS32;
      else if (m.half_timer_mode_field == GTM_MR_PER)
        r = OP_PER32;
    end
    else if (cfg == GTM_CFG_RTC)
      r = OP_RTC;
    else if (cfg == GTM_CFG_16)
    begin
      if (m.half_timer_mode_field == GTM_MR_CAP)
        r = m.capture_mode_select ? OP_ETIME : OP_ECNT;
      else if (m.half_timer_mode_field == GTM_MR_PER &&
               m.alternate_mode_select && !m.capture_mode_select)
        r = OP_PWM;
      else if (m.half_timer_mode_field == GTM_MR_OS)
        r = OP_OS16;
      else if (m.half_timer_mode_field == GTM_MR_PER)
        r = OP_PER16;
    end
    return r;
  endfunction : op_decode

  // Event type: 0 rising, 1 falling, 3 both, 2 none
  function automatic logic edge_hit(input logic [1:0] evt,
                                    input logic       r,
                                    input logic       f);
    logic h;
    case (evt)
      2'b00:   h = r;
      2'b01:   h = f;
      2'b11:   h = r | f;
      default: h = 1'b0;
    endcase
    return h;
  endfunction : edge_hit

  // One down-count step; zero reloads from the interval
  function automatic logic [31:0] count_step(input logic [31:0] cnt,
                                             input logic [31:0] load);
    logic [31:0] n;
    if (cnt == 32'h0000_0000)
      n = load;
    else
      n = cnt - 32'h0000_0001;
    return n;
  endfunction : count_step

  always_comb
  begin
    next_st   = st;
    next_sync = {sync[1:0], ccp_in};
    // Level accepted once stages two and three agree
    next_lvl  = (sync[1] == sync[2]) ? sync[2] : lvl;
    rise      = next_lvl & ~lvl;
    fall      = ~next_lvl & lvl;
    hit       = edge_hit(st.ctl.edge_event_type, rise, fall);
    op        = op_decode(st.cfg, st.mode);
    wide      = (op == OP_OS32) || (op == OP_PER32);
    one_shot  = (op == OP_OS32) || (op == OP_OS16);
    // Sixteen-bit modes count in the low half only
    lv        = wide ? st.ilr : {16'h0000, st.ilr[15:0]};
    set       = 4'h0;
    clr       = 4'h0;
    tick      = 1'b0;
    next_rd_data = 32'h0000_0000;

    // RTC pin clock divided down to one tick per second
    if (op == OP_RTC && st.ctl.half_timer_enable && rise)
    begin
      next_st.rdiv = st.rdiv + 15'h0001;
      tick = (st.rdiv == `GTM_RTC_DIV_LAST);
    end

    if (!st.ctl.half_timer_enable)
      next_st.pwm_lvl = 1'b0;
    else
    begin
      case (op)
        OP_OS32, OP_PER32, OP_OS16, OP_PER16:
        begin
          // Prescaler stretches 16-bit steps only
          if (!wide && st.pre != 8'h00)
            next_st.pre = st.pre - 8'h01;
          else if (st.cnt == 32'h0000_0000)
          begin
            next_st.cnt = lv;
            next_st.pre = st.pr;
            set[`GTM_FLAG_TO] = 1'b1;
            if (one_shot)
              next_st.ctl.half_timer_enable = 1'b0;
          end
          else
          begin
            next_st.cnt = st.cnt - 32'h0000_0001;
            next_st.pre = st.pr;
          end
        end
        OP_RTC:
        begin
          if (tick)
          begin
            if (st.cnt == st.match)
            begin
              next_st.cnt = 32'h0000_0000;
              set[`GTM_FLAG_RTC] = 1'b1;
            end
            else
              next_st.cnt = st.cnt + 32'h0000_0001;
          end
        end
        OP_ECNT:
        begin
          // Prescaler bypassed in capture and PWM modes
          if (hit)
          begin
            // Match seen on the value this edge would leave
            if (st.cnt[15:0] - 16'h0001 == st.match[15:0])
            begin
              set[`GTM_FLAG_CM] = 1'b1;
              next_st.cnt = lv;
              next_st.ctl.half_timer_enable = 1'b0;
            end
            else
              next_st.cnt = st.cnt - 32'h0000_0001;
          end
        end
        OP_ETIME:
        begin
          next_st.cnt = count_step(st.cnt, lv);
          // Capture keeps the count from before this step
          if (hit)
          begin
            next_st.cap = st.cnt[15:0];
            set[`GTM_FLAG_CE] = 1'b1;
          end
        end
        OP_PWM:
        begin
          next_st.cnt = count_step(st.cnt, lv);
          // Level moves only at load and match, never between
          if (st.cnt == lv)
            next_st.pwm_lvl = 1'b1;
          else if (st.cnt[15:0] == st.match[15:0])
            next_st.pwm_lvl = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    if (wr_en)
    begin
      case (addr)
        `GTM_OFS_CFG:   next_st.cfg = wr_data[2:0];
        `GTM_OFS_MODE:  next_st.mode = gtm_mode_t'(wr_data[3:0]);
        `GTM_OFS_CTL:
        begin
          next_st.ctl.half_timer_enable = wr_data[`GTM_CTL_EN];
          next_st.ctl.edge_event_type =
            wr_data[`GTM_CTL_EVT +: 2];
          next_st.ctl.rtc_debug_stall_override =
            wr_data[`GTM_CTL_RTC_DEBUG_STALL_OVERRIDE];
          next_st.ctl.pwm_output_level = wr_data[`GTM_CTL_PWML];
          // Enable starts the count from the preloaded value; RTC mode starts from GTM_RTC_START
          if (wr_data[`GTM_CTL_EN] && !st.ctl.half_timer_enable)
          begin
            next_st.cnt  = (op == OP_RTC) ? `GTM_RTC_START : lv;
            next_st.pre  = st.pr;
            next_st.rdiv = 15'h0000;
          end
        end
        `GTM_OFS_IMR:   next_st.imr = wr_data[3:0];
        `GTM_OFS_ICR:   clr = wr_data[3:0];
        `GTM_OFS_ILR:
        begin
          next_st.ilr = wr_data;
          // While enabled, a new interval takes effect on the next cycle, except in edge count and RTC modes
          if (st.ctl.half_timer_enable && op != OP_ECNT &&
              op != OP_RTC)
            next_st.cnt = wide ? wr_data : {16'h0000, wr_data[15:0]};
        end
        `GTM_OFS_MATCH: next_st.match = wr_data;
        `GTM_OFS_PR:    next_st.pr = wr_data[7:0];
        default:
        begin
        end
      endcase
    end

    // New event wins over a clear in the same cycle
    next_st.ris = (st.ris & ~clr) | set;

    // Read data stands one cycle, zero otherwise
    if (rd_en)
    begin
      case (addr)
        `GTM_OFS_CFG:   next_rd_data = {29'h0, st.cfg};
        `GTM_OFS_MODE:  next_rd_data = {28'h0, st.mode};
        `GTM_OFS_CTL:
        begin
          next_rd_data[`GTM_CTL_EN] = st.ctl.half_timer_enable;
          next_rd_data[`GTM_CTL_EVT +: 2] = st.ctl.edge_event_type;
          next_rd_data[`GTM_CTL_RTC_DEBUG_STALL_OVERRIDE] =
            st.ctl.rtc_debug_stall_override;
          next_rd_data[`GTM_CTL_PWML] = st.ctl.pwm_output_level;
        end
        `GTM_OFS_IMR:   next_rd_data = {28'h0, st.imr};
        `GTM_OFS_RIS:   next_rd_data = {28'h0, st.ris};
        `GTM_OFS_MIS:   next_rd_data = {28'h0, st.ris & st.imr};
        `GTM_OFS_ILR:   next_rd_data = st.ilr;
        `GTM_OFS_MATCH: next_rd_data = st.match;
        `GTM_OFS_PR:    next_rd_data = {24'h0, st.pr};
        `GTM_OFS_VAL:
          next_rd_data = (op == OP_ETIME) ?
                         {16'h0000, st.cap} : st.cnt;
        default:        next_rd_data = 32'h0000_0000;
      endcase
    end

    // Pin driven in PWM mode even while disabled
    next_ccp_oe  = (op == OP_PWM);
    next_ccp_out = (op == OP_PWM) &&
                   (next_st.pwm_lvl ^ st.ctl.pwm_output_level);
  end

  // Synchronous reset; pin stages start at the idle low level
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      st <= '{ilr: `GTM_ILR_RST, match: `GTM_MATCH_RST,
              cnt: `GTM_CNT_RST, default: '0};
      sync    <= 3'h0;
      lvl     <= 1'b0;
      rd_data <= 32'h0000_0000;
      ccp_out <= 1'b0;
      ccp_oe  <= 1'b0;
    end
    else
    begin
      st      <= next_st;
      sync    <= next_sync;
      lvl     <= next_lvl;
      rd_data <= next_rd_data;
      ccp_out <= next_ccp_out;
      ccp_oe  <= next_ccp_oe;
    end
  end

endmodule : gtm_timer

/* bench/gtm_timer_properties.sv */
/* Checker for the timer's register port and pin outputs.
   Bound to gtm_timer; sees its ports only. */
`timescale 1ns/10ps
`include "gtm_regs.svh"
module gtm_timer_properties (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rstn,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  // Pin
  input wire logic        ccp_in,
  input wire logic        ccp_out,
  input wire logic        ccp_oe
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_rd_idle_zero: assert property (!rd_en |=> rd_data == 32'h0)
    else $error("read data outside read");
  a_icr_reads_zero: assert property (
    rd_en && addr == `GTM_OFS_ICR |=> rd_data == 32'h0)
    else $error("clear register read not zero");
  a_unmapped_zero: assert property (
    rd_en && addr == 12'h008 |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (
    wr_en && addr == `GTM_OFS_CFG ##1 !wr_en ##1
    rd_en && addr == `GTM_OFS_CFG
    |=> rd_data[2:0] == $past(wr_data[2:0], 3))
    else $error("config readback wrong");
  a_cfg_drops_oe: assert property (
    wr_en && addr == `GTM_OFS_CFG && wr_data[2:0] != 3'h4
    |-> ##2 !ccp_oe)
    else $error("enable kept outside 16-bit");
  a_mode_drops_oe: assert property (
    wr_en && addr == `GTM_OFS_MODE && wr_data[3:0] != 4'hA
    |-> ##2 !ccp_oe)
    else $error("enable kept outside pwm");
  a_out_rise_oe: assert property ($rose(ccp_out) |-> ccp_oe)
    else $error("output rose without enable");
  a_reset_quiet: assert property (
    $rose(rstn) |-> !ccp_oe && !ccp_out && rd_data == 32'h0)
    else $error("outputs active after reset");
endmodule : gtm_timer_properties

/* bench/gtm_pin_model.sv */
/* Far side of the capture pin: toggles it on request.
   Assumes the bench spaces its requests. */
`timescale 1ns/10ps
module gtm_pin_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Request and pin
  input wire logic go,
  output logic     pin
);
  logic [1:0] held;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pin  <= 1'b0;
      held <= 2'd0;
    end
    else if (go && held == 2'd3)
    begin
      pin  <= ~pin;
      held <= 2'd0;
    end
    else if (held != 2'd3)
      held <= held + 2'd1;
  end
endmodule : gtm_pin_model

/* bench/tb_gtm_timer.sv */
/* Self-checking bench for the general timer module.
   Assumes the pin model and checker compile first. */
`timescale 1ns/10ps
`include "gtm_regs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_gtm_timer;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [11:0] addr    = 12'h000;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic        go      = 1'b0;
  logic        rd_dly  = 1'b0;
  logic [31:0] seed    = 32'h37ec_8091;
  logic [31:0] rd_data;
  logic        ccp_out;
  logic        ccp_oe;
  logic        pin;
  logic        ccp_in;
  logic [31:0] last_rd;
  logic [31:0] v1;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          error_cnt = 0;
  int          compares  = 0;

  always #25 sys_clk = ~sys_clk;
  assign ccp_in = ccp_oe ? ccp_out : pin;

  gtm_timer i_dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe));
  gtm_pin_model i_pin (.sys_clk(sys_clk), .rstn(rstn), .go(go),
    .pin(pin));

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en   <= 1'b0;
  endtask : wr

  // Mask of zero notes the read without comparing
  task automatic rd(input logic [11:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr  <= a;
    msk_q.push_back(m);
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd_en <= 1'b0;
    @(negedge sys_clk);
    #1;
  endtask : rd

  task automatic pin_edge();
    @(posedge sys_clk);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (6 + xs() % 4) @(posedge sys_clk);
  endtask : pin_edge

  task automatic count_high(input logic [4:0] n);
    logic [4:0] k;
    k = 5'd0;
    repeat (20)
    begin
      @(negedge sys_clk);
      k = k + {4'h0, ccp_out};
    end
    `CHK(k, n)
  endtask : count_high

  task automatic give_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  always @(posedge sys_clk)
    rd_dly <= rd_en;

  always @(negedge sys_clk)
    if (rd_dly)
    begin
      last_rd = rd_data;
      if (msk_q[0] != 32'h0)
        `CHK(rd_data & msk_q[0], exp_q[0])
      void'(msk_q.pop_front());
      void'(exp_q.pop_front());
    end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(`GTM_OFS_ILR, 32'hFFFF_FFFF, `GTM_ILR_RST);
    rd(`GTM_OFS_VAL, 32'hFFFF_FFFF, `GTM_CNT_RST);
    rd(12'h008, 32'hFFFF_FFFF, 32'h0);
    rd(`GTM_OFS_ICR, 32'hFFFF_FFFF, 32'h0);
    v1 = xs();
    wr(`GTM_OFS_MATCH, v1);
    rd(`GTM_OFS_MATCH, 32'hFFFF_FFFF, v1);
    // One-shot and periodic, 32 and 16 bit
    for (int c = 0; c <= 4; c += 4)
      for (int md = 1; md <= 2; md++)
      begin
        wr(`GTM_OFS_CTL, 32'h0);
        wr(`GTM_OFS_CFG, 32'(c));
        rd(`GTM_OFS_CFG, 32'h7, 32'(c));
        wr(`GTM_OFS_MODE, 32'(md));
        wr(`GTM_OFS_ICR, 32'hF);
        wr(`GTM_OFS_ILR, 32'h5);
        wr(`GTM_OFS_CTL, 32'h1);
        repeat (20) @(posedge sys_clk);
        rd(`GTM_OFS_RIS, 32'h1, 32'h1);
        rd(`GTM_OFS_CTL, 32'h1, 32'(md - 1));
        if (md == 1)
        begin
          wr(`GTM_OFS_ICR, 32'h1);
          rd(`GTM_OFS_RIS, 32'h1, 32'h0);
        end
      end
    // Edge count, both edges, four to match
    wr(`GTM_OFS_CTL, 32'h0);
    wr(`GTM_OFS_MODE, 32'h3);
    wr(`GTM_OFS_ILR, 32'hA);
    wr(`GTM_OFS_MATCH, 32'h6);
    wr(`GTM_OFS_IMR, 32'h2);
    wr(`GTM_OFS_CTL, 32'hD);
    repeat (3) pin_edge();
    rd(`GTM_OFS_VAL, 32'hFFFF, 32'h7);
    repeat (3) pin_edge();
    rd(`GTM_OFS_RIS, 32'h2, 32'h2);
    rd(`GTM_OFS_MIS, 32'h2, 32'h2);
    rd(`GTM_OFS_CTL, 32'h1, 32'h0);
    rd(`GTM_OFS_VAL, 32'hFFFF, 32'hA);
    // Edge time, rising only
    wr(`GTM_OFS_MODE, 32'h7);
    wr(`GTM_OFS_ILR, 32'hFFFF);
    wr(`GTM_OFS_IMR, 32'h4);
    wr(`GTM_OFS_CTL, 32'h1);
    pin_edge();
    rd(`GTM_OFS_RIS, 32'h4, 32'h4);
    rd(`GTM_OFS_MIS, 32'h4, 32'h4);
    rd(`GTM_OFS_VAL, 32'h0, 32'h0);
    v1 = last_rd;
    `CHK(v1 > 32'hFF00 && v1 < 32'h1_0000, 1'b1)
    pin_edge();
    rd(`GTM_OFS_VAL, 32'hFFFF_FFFF, v1);
    pin_edge();
    rd(`GTM_OFS_VAL, 32'h0, 32'h0);
    `CHK(last_rd < v1, 1'b1)
    // Short interval: capture must come from a reloaded count
    wr(`GTM_OFS_ILR, 32'h3);
    repeat (2) pin_edge();
    rd(`GTM_OFS_VAL, 32'h0, 32'h0);
    `CHK(last_rd < 32'h4, 1'b1)
    // PWM, period ten, prescaler set but bypassed
    wr(`GTM_OFS_CTL, 32'h0);
    wr(`GTM_OFS_MODE, 32'hA);
    wr(`GTM_OFS_PR, 32'h5);
    wr(`GTM_OFS_ILR, 32'h9);
    wr(`GTM_OFS_MATCH, 32'h3);
    wr(`GTM_OFS_ICR, 32'hF);
    wr(`GTM_OFS_CTL, 32'h1);
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ccp_oe, 1'b1)
    count_high(5'd12);
    rd(`GTM_OFS_RIS, 32'hFFFF_FFFF, 32'h0);
    wr(`GTM_OFS_CTL, 32'h0);
    wr(`GTM_OFS_CTL, 32'h41);
    repeat (12) @(posedge sys_clk);
    count_high(5'd8);
    // RTC start value; too few pin rises to reach a tick
    wr(`GTM_OFS_CTL, 32'h0);
    wr(`GTM_OFS_CFG, 32'h1);
    wr(`GTM_OFS_MATCH, 32'h2);
    wr(`GTM_OFS_CTL, 32'h1);
    repeat (2) pin_edge();
    rd(`GTM_OFS_VAL, 32'hFFFF_FFFF, `GTM_RTC_START);
    rd(`GTM_OFS_RIS, 32'h8, 32'h0);
    give_verdict();
  end
endmodule : tb_gtm_timer

bind gtm_timer gtm_timer_properties i_chk (.sys_clk(sys_clk),
  .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .ccp_in(ccp_in),
  .ccp_out(ccp_out), .ccp_oe(ccp_oe));
